// ---- src/break_comparator_defines.vh ----
`ifndef BREAK_COMPARATOR_DEFINES_VH
`define BREAK_COMPARATOR_DEFINES_VH
// Register indices, byte address is four times the index
`define REG_CHAN0_MATCH_CONDITION 4'h0
`define REG_CHAN0_MATCH_OPERATION 4'h1
`define REG_CHAN0_BREAK_ADDRESS 4'h2
`define REG_CHAN0_ADDRESS_MASK 4'h3
`define REG_CHAN1_MATCH_CONDITION 4'h4
`define REG_CHAN1_MATCH_OPERATION 4'h5
`define REG_CHAN1_BREAK_ADDRESS 4'h6
`define REG_CHAN1_ADDRESS_MASK 4'h7
`define REG_CHAN1_BREAK_DATA 4'h8
`define REG_CHAN1_DATA_MASK 4'h9
`define REG_CHAN1_HIT_COUNTDOWN 4'ha
`define REG_CHANNEL_MATCH_FLAGS 4'hb
`define REG_BREAK_SUPPORT_CONTROL 4'hc
// Condition register fields
`define COND_ENABLE 0
`define COND_READ 1
`define COND_WRITE 2
`define COND_FETCH 4
`define COND_OPERAND 5
`define COND_BUS_LO 6
`define COND_SIZE_LO 8
`define COND_SIZE_HI 10
`define COND_DATA_EN 11
`define COND_COUNT_EN 12
`define COND_ADDRESS_SPACE_IDENTIFIER_EN 13
`define COND_ADDRESS_SPACE_IDENTIFIER_LO 16
`define COND_ADDRESS_SPACE_IDENTIFIER_HI 23
`define COND_FLAG_SEL 24
`define COND_FLAG_EN 25
// Operation register fields
`define OPER_BREAK_EN 0
`define OPER_AFTER 1
// Operand size codes
`define SIZE_ANY 3'h0
`define SIZE_BYTE 3'h1
`define SIZE_WORD 3'h2
`define SIZE_LONG 3'h3
`define SIZE_QUAD 3'h4
// Access size code of a full word register access
`define ACC_LONG 2'h2
// Reset value, count limit and value read by a wrong-size access
`define RST_WORD 32'h0000_0000
`define COUNT_MAX 12'hfff
`define READ_UNDEF 32'h0000_0000
`endif

// ---- src/break_comparator.v ----
// Behaviour
// [RULE1] Two break channels, each programmed and evaluated independently.
// [RULE2] Sequential mode breaks only after other channel hit in earlier cycle.
// [RULE3] Address compare covers identifier plus 32-bit address; id all or none.
// [RULE4] Per-channel 32-bit address mask; mask bit 1 excludes that bit.
// [RULE5] Channel 1 alone compares masked 32-bit bus data against stored value.
// [RULE6] Each channel picks fetch or operand, read or write, and size.
// [RULE7] Quadword data match compares both 32-bit halves against value.
// [RULE8] Cache ops come as longword accesses without data; no data match.
// [RULE9] Software enabling data match also programs a specific size.
// [RULE10] Fetch matches break before or after the instruction, as selected.
// [RULE11] Operation register enables break request and fetch break timing.
// [RULE12] Counting enabled: each channel 1 hit decrements the count register; the code holds the count once it is 0.
// [RULE13] Count enabled: break on hit when count already holds 1; 12 bits.
// [RULE14] Satisfied condition sets the channel's sticky hit flag.
// [RULE15] Writing the flag register stores written value AND current flags.
// [RULE16] Wrong-size accesses do not write and read an undefined value.
// [RULE17] New register values take effect by the next cycle after write.
// [RULE18] Condition register holds flag, id, data, size, count, bus, type.
// [RULE19] Each channel has an address register; channel 1 a data register.
// [RULE20] Support control register selects the extra debug support function.
// [RULE21] Block bit set: flags still set but no break request raised.
// [RULE22] Simultaneous hits on both channels give one break request.
// [RULE23] Fetch matches need address bit 0 cleared by software, else none.
// [RULE24] Operand address compare drops low bits by size: 3, 2 or 1.
// [RULE25] Reset leaves channels disabled and flags clear.
// [RULE26] Break request goes out tagged before or after the instruction.
`timescale 1ns/1ps
`include "break_comparator_defines.vh"
module break_comparator (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control register port
  input wire reg_req,
  input wire reg_wr,
  input wire [3:0] reg_idx,
  input wire [1:0] reg_size,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  // Observed bus cycle
  input wire cyc_valid,
  input wire cyc_fetch,
  input wire cyc_write,
  input wire [2:0] cyc_size,
  input wire [1:0] cyc_bus,
  input wire cyc_has_data,
  input wire [31:0] cyc_addr,
  input wire [7:0] cyc_address_space_identifier,
  input wire [63:0] cyc_data,
  // Processor state
  input wire exception_block_bit,
  // Break request, support enable and hit flags to the core
  output reg break_req,
  output reg break_after,
  output reg debug_support_en,
  output reg [1:0] hit_flags
);

  reg [31:0] cond_q [0:1];
  reg [31:0] oper_q [0:1];
  reg [31:0] addr_q [0:1];
  reg [31:0] amask_q [0:1];
  reg [31:0] bdata_q;
  reg [31:0] dmask_q;
  reg [11:0] count_q;
  reg [1:0] flags_q;
  reg ctrl_q;

  // Low address bits ignored for an operand access of given size
  function [31:0] size_mask;
    input [2:0] sz;
    begin
      case (sz)
        `SIZE_QUAD: size_mask = 32'h0000_0007;
        `SIZE_LONG: size_mask = 32'h0000_0003;
        `SIZE_WORD: size_mask = 32'h0000_0001;
        default: size_mask = 32'h0000_0000;
      endcase
    end
  endfunction

  wire wr_ok = reg_req && reg_wr && (reg_size == `ACC_LONG); // [RULE16]

  // Per-channel condition evaluation
  wire [1:0] hit;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan // [RULE1]
      wire [31:0] c = cond_q[ch];
      wire [31:0] ign;
      wire addr_ok;
      wire address_space_identifier_ok;
      wire type_ok;
      wire rw_ok;
      wire size_ok;
      wire bus_ok;
      wire data_ok;
      wire seq_ok;
      wire [2:0] csz = c[`COND_SIZE_HI:`COND_SIZE_LO];
      assign ign = amask_q[ch] | (cyc_fetch ? 32'h0000_0000 :
        size_mask(cyc_size)); // [RULE4] [RULE24]
      assign addr_ok = ((cyc_addr ^ addr_q[ch]) & ~ign) == 32'h0000_0000 &&
        !(cyc_fetch && addr_q[ch][0]); // [RULE23]
      assign address_space_identifier_ok = !c[`COND_ADDRESS_SPACE_IDENTIFIER_EN] ||
        (cyc_address_space_identifier == c[`COND_ADDRESS_SPACE_IDENTIFIER_HI:`COND_ADDRESS_SPACE_IDENTIFIER_LO]); // [RULE3]
      assign type_ok = cyc_fetch ? c[`COND_FETCH] :
        c[`COND_OPERAND]; // [RULE6]
      assign rw_ok = cyc_fetch ||
        (cyc_write ? c[`COND_WRITE] : c[`COND_READ]);
      assign size_ok = cyc_fetch || csz == `SIZE_ANY || csz == cyc_size;
      assign bus_ok = c[`COND_BUS_LO+1:`COND_BUS_LO] == 2'h0 ||
        c[`COND_BUS_LO+1:`COND_BUS_LO] == cyc_bus;
      if (ch == 1) begin : g_data
        wire lo_ok = ((cyc_data[31:0] ^ bdata_q) & ~dmask_q) ==
          32'h0000_0000; // [RULE5]
        wire hi_ok = ((cyc_data[63:32] ^ bdata_q) & ~dmask_q) ==
          32'h0000_0000; // [RULE7]
        // Fetches bypass the data compare; dataless cache ops never pass it
        assign data_ok = !c[`COND_DATA_EN] || cyc_fetch ||
          (cyc_has_data && lo_ok &&
          (cyc_size != `SIZE_QUAD || hi_ok)); // [RULE8]
      end else begin : g_nodata
        assign data_ok = 1'b1;
      end
      assign seq_ok = !c[`COND_FLAG_EN] ||
        flags_q[c[`COND_FLAG_SEL]]; // [RULE2]
      assign hit[ch] = cyc_valid && c[`COND_ENABLE] && addr_ok && address_space_identifier_ok &&
        type_ok && rw_ok && size_ok && bus_ok && data_ok && seq_ok; // [RULE18]
    end
  endgenerate

  // Channel 1 count gates the match
  wire cnt_en = cond_q[1][`COND_COUNT_EN];
  wire [1:0] match = {hit[1] && (!cnt_en || count_q == 12'h001),
    hit[0]}; // [RULE13]
  wire [1:0] req_ch = match & {oper_q[1][`OPER_BREAK_EN],
    oper_q[0][`OPER_BREAK_EN]}; // [RULE11]
  wire any_req = |req_ch; // [RULE22]
  wire after_sel = req_ch[0] ? oper_q[0][`OPER_AFTER] :
    oper_q[1][`OPER_AFTER]; // [RULE10]

  wire [1:0] flags_wr = (wr_ok && reg_idx == `REG_CHANNEL_MATCH_FLAGS) ?
    (flags_q & reg_wdata[1:0]) : flags_q; // [RULE15]

  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 2; i = i + 1) begin
        cond_q[i] <= `RST_WORD; // [RULE25]
        oper_q[i] <= `RST_WORD;
        addr_q[i] <= `RST_WORD;
        amask_q[i] <= `RST_WORD;
      end
      bdata_q <= `RST_WORD;
      dmask_q <= `RST_WORD;
      count_q <= 12'h000;
      flags_q <= 2'b00;
      ctrl_q <= 1'b0;
      reg_rdata <= `RST_WORD;
      reg_ack <= 1'b0;
      break_req <= 1'b0;
      break_after <= 1'b0;
      debug_support_en <= 1'b0;
      hit_flags <= 2'b00;
    end else begin
      // Register writes, visible to the matcher next cycle
      if (wr_ok) begin // [RULE17]
        if (reg_idx == `REG_CHAN0_MATCH_CONDITION) begin
          cond_q[0] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN0_MATCH_OPERATION) begin
          oper_q[0] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN0_BREAK_ADDRESS) begin
          addr_q[0] <= reg_wdata; // [RULE19]
        end else if (reg_idx == `REG_CHAN0_ADDRESS_MASK) begin
          amask_q[0] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN1_MATCH_CONDITION) begin
          cond_q[1] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN1_MATCH_OPERATION) begin
          oper_q[1] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN1_BREAK_ADDRESS) begin
          addr_q[1] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN1_ADDRESS_MASK) begin
          amask_q[1] <= reg_wdata;
        end else if (reg_idx == `REG_CHAN1_BREAK_DATA) begin
          bdata_q <= reg_wdata;
        end else if (reg_idx == `REG_CHAN1_DATA_MASK) begin
          dmask_q <= reg_wdata;
        end else if (reg_idx == `REG_BREAK_SUPPORT_CONTROL) begin
          ctrl_q <= reg_wdata[0]; // [RULE20]
        end
      end
      // Counter: hit decrements, write reloads, hit wins
      if (hit[1] && cnt_en && count_q != 12'h000) begin
        count_q <= count_q - 12'h001; // [RULE12]
      end else if (wr_ok && reg_idx == `REG_CHAN1_HIT_COUNTDOWN) begin
        count_q <= reg_wdata[11:0];
      end
      // Flags: set wins over clear
      flags_q <= flags_wr | match; // [RULE14]
      hit_flags <= flags_wr | match;
      // Reads
      reg_ack <= reg_req;
      if (reg_req && !reg_wr) begin
        if (reg_size != `ACC_LONG) begin
          reg_rdata <= `READ_UNDEF;
        end else if (reg_idx == `REG_CHAN0_MATCH_CONDITION) begin
          reg_rdata <= cond_q[0];
        end else if (reg_idx == `REG_CHAN0_MATCH_OPERATION) begin
          reg_rdata <= oper_q[0];
        end else if (reg_idx == `REG_CHAN0_BREAK_ADDRESS) begin
          reg_rdata <= addr_q[0];
        end else if (reg_idx == `REG_CHAN0_ADDRESS_MASK) begin
          reg_rdata <= amask_q[0];
        end else if (reg_idx == `REG_CHAN1_MATCH_CONDITION) begin
          reg_rdata <= cond_q[1];
        end else if (reg_idx == `REG_CHAN1_MATCH_OPERATION) begin
          reg_rdata <= oper_q[1];
        end else if (reg_idx == `REG_CHAN1_BREAK_ADDRESS) begin
          reg_rdata <= addr_q[1];
        end else if (reg_idx == `REG_CHAN1_ADDRESS_MASK) begin
          reg_rdata <= amask_q[1];
        end else if (reg_idx == `REG_CHAN1_BREAK_DATA) begin
          reg_rdata <= bdata_q;
        end else if (reg_idx == `REG_CHAN1_DATA_MASK) begin
          reg_rdata <= dmask_q;
        end else if (reg_idx == `REG_CHAN1_HIT_COUNTDOWN) begin
          reg_rdata <= {20'h0_0000, count_q};
        end else if (reg_idx == `REG_CHANNEL_MATCH_FLAGS) begin
          reg_rdata <= {30'h0000_0000, flags_q};
        end else if (reg_idx == `REG_BREAK_SUPPORT_CONTROL) begin
          reg_rdata <= {31'h0000_0000, ctrl_q};
        end else begin
          reg_rdata <= `RST_WORD;
        end
      end
      // Single request, suppressed while the core blocks exceptions
      break_req <= any_req && !exception_block_bit; // [RULE21] [RULE22]
      break_after <= any_req && after_sel; // [RULE26]
      debug_support_en <= ctrl_q;
    end
  end

endmodule // break_comparator

// ---- dv/break_comparator_monitor.sv ----
`timescale 1ns/1ps
module break_comparator_monitor (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire reg_req,
  input wire reg_wr,
  input wire [3:0] reg_idx,
  input wire [1:0] reg_size,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire reg_ack,
  // Bus cycle and break
  input wire cyc_valid,
  input wire exception_block_bit,
  input wire break_req,
  input wire [1:0] hit_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire fw = reg_req && reg_wr && reg_idx == 4'hb && reg_size == 2'h2;
  a_ack_follows: assert property (reg_req |=> reg_ack)
    else $error("ack missing");
  a_ack_only: assert property (!reg_req |=> !reg_ack)
    else $error("stray ack");
  a_bad_size_read: assert property (
    reg_req && !reg_wr && reg_size != 2'h2 |=> reg_rdata == 32'h0000_0000)
    else $error("wrong size read not zero");
  a_block_quiet: assert property (exception_block_bit |=> !break_req)
    else $error("break while blocked");
  a_idle_no_break: assert property (!cyc_valid |=> !break_req)
    else $error("break without cycle");
  a_break_flags: assert property (break_req |-> hit_flags != 2'h0)
    else $error("break without flag");
  a_flags_sticky: assert property (
    !fw |=> (hit_flags & $past(hit_flags)) == $past(hit_flags))
    else $error("flag cleared itself");
  a_flags_and: assert property (
    fw && !cyc_valid |=> hit_flags == ($past(hit_flags) & $past(reg_wdata[1:0])))
    else $error("flag write not AND");
endmodule // break_comparator_monitor
bind break_comparator break_comparator_monitor i_mon (.clk, .rstn, .reg_req,
  .reg_wr, .reg_idx, .reg_size, .reg_wdata, .reg_rdata, .reg_ack, .cyc_valid,
  .exception_block_bit, .break_req, .hit_flags);

// ---- dv/core_bus_model.sv ----
`timescale 1ns/1ps
module core_bus_model (
  // Clock
  input wire clk,
  // Bus cycle
  output reg cyc_valid = 0,
  output reg cyc_fetch = 0,
  output reg cyc_write = 0,
  output reg [2:0] cyc_size = 0,
  output reg [1:0] cyc_bus = 0,
  output reg cyc_has_data = 1,
  output reg [31:0] cyc_addr = 0,
  output reg [7:0] cyc_address_space_identifier = 0,
  output reg [63:0] cyc_data = 0
);
  // Qualifiers that stay put between cycles: data present, space id
  task side(input hd, input [7:0] id);
    begin
      cyc_has_data = hd;
      cyc_address_space_identifier = id;
    end
  endtask
  // One bus cycle, then inverted lines
  task cyc(input f, input w, input [2:0] sz, input [31:0] a, input [63:0] d);
    begin
      @(negedge clk);
      {cyc_valid, cyc_fetch, cyc_write, cyc_size} = {1'b1, f, w, sz};
      cyc_addr = a;
      cyc_data = d;
      @(negedge clk);
      cyc_valid = 1'b0;
      // Stale lines would hide a missed qualifier
      cyc_addr = ~a;
      cyc_data = ~d;
    end
  endtask
endmodule // core_bus_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`include "break_comparator_defines.vh"
module testbench;
  reg clk = 0, rstn = 0, reg_req = 0, reg_wr = 0, exception_block_bit = 0;
  reg [3:0] reg_idx = 0;
  reg [1:0] reg_size = 2;
  reg [31:0] reg_wdata = 0, rd, a, seed = 32'h304d_12e8;
  reg e;
  integer n_fail = 0, checked = 0, i;
  wire [31:0] reg_rdata, ca;
  wire reg_ack, break_req, break_after, dbg, cv, cf, cw, chd;
  wire [2:0] cs;
  wire [1:0] cb, hit_flags;
  wire [7:0] cid;
  wire [63:0] cd;
  always #2 clk = ~clk;
  break_comparator i_dut (.clk(clk), .rstn(rstn), .reg_req(reg_req),
    .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_size(reg_size),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .cyc_valid(cv), .cyc_fetch(cf), .cyc_write(cw), .cyc_size(cs),
    .cyc_bus(cb), .cyc_has_data(chd), .cyc_addr(ca), .cyc_address_space_identifier(cid),
    .cyc_data(cd), .exception_block_bit(exception_block_bit),
    .break_req(break_req), .break_after(break_after),
    .debug_support_en(dbg), .hit_flags(hit_flags));
  core_bus_model i_cpu (.clk(clk), .cyc_valid(cv), .cyc_fetch(cf),
    .cyc_write(cw), .cyc_size(cs), .cyc_bus(cb), .cyc_has_data(chd),
    .cyc_addr(ca), .cyc_address_space_identifier(cid), .cyc_data(cd));
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rw(input w, input [3:0] ix, input [1:0] sz, input [31:0] d);
    begin
      @(negedge clk);
      {reg_req, reg_wr, reg_idx, reg_size, reg_wdata} = {1'b1, w, ix, sz, d};
      @(negedge clk);
      reg_req = 1'b0;
      rd = reg_rdata;
    end
  endtask
  // Answer is {after, break, flags} one cycle on
  task hit(input f, input w, input [2:0] sz, input [31:0] ad,
    input [63:0] d, input [3:0] x);
    begin
      i_cpu.cyc(f, w, sz, ad, d);
      chk({break_after, break_req, hit_flags}, x);
    end
  endtask
  task test_done;
    begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    rw(0, 4'h0, 2, 0);
    chk({rd, hit_flags}, 0);
    seed = xs(seed);
    rw(1, 4'h8, 2, seed);
    rw(1, 4'h8, 1, ~seed);
    rw(0, 4'h8, 2, 0);
    chk(rd, seed);
    rw(0, 4'h8, 0, 0);
    chk(rd, `READ_UNDEF);
    rw(1, 4'hc, 2, 1);
    rw(0, 4'hc, 2, 0);
    chk({rd[0], dbg}, 3);
    $display("register test done");
    rw(1, 4'h2, 2, 32'h1234_5000);
    rw(1, 4'h3, 2, 32'h0000_00f0);
    rw(1, 4'h1, 2, 1);
    rw(1, 4'h0, 2, 32'h0000_0323);
    rw(0, 4'h0, 2, 0);
    hit(0, 0, 3, 32'h1234_50f3, 0, 4'h5);
    hit(0, 1, 3, 32'h1234_5000, 0, 4'h1);
    hit(0, 0, 1, 32'h1234_5000, 0, 4'h1);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      a = 32'h1234_5000 ^ (seed & 32'h0000_01f7);
      e = ((a ^ 32'h1234_5000) & 32'hffff_ff0c) == 0;
      hit(0, 0, 3, a, {2{seed}}, {1'b0, e, 2'b01});
    end
    rw(1, 4'hb, 2, 32'hffff_ffff);
    rw(0, 4'hb, 2, 0);
    chk(hit_flags, 1);
    rw(1, 4'hb, 2, 32'hffff_fffe);
    rw(0, 4'hb, 2, 0);
    chk(hit_flags, 0);
    exception_block_bit = 1;
    hit(0, 0, 3, 32'h1234_5000, 0, 4'h1);
    exception_block_bit = 0;
    rw(1, 4'h0, 2, 32'h0000_2323);
    i_cpu.side(1, 8'h55);
    hit(0, 0, 3, 32'h1234_5000, 0, 4'h1);
    i_cpu.side(1, 8'h00);
    hit(0, 0, 3, 32'h1234_5000, 0, 4'h5);
    rw(1, 4'hb, 2, 0);
    $display("channel 0 test done");
    rw(1, 4'h6, 2, 32'h0000_8000);
    rw(1, 4'h8, 2, 32'hcafe_0000);
    rw(1, 4'h9, 2, 32'h0000_ffff);
    rw(1, 4'ha, 2, 2);
    rw(1, 4'h5, 2, 1);
    rw(1, 4'h4, 2, 32'h0000_1c25);
    rw(0, 4'h4, 2, 0);
    hit(0, 1, 4, 32'h0000_8000, 64'hcafe_1234_cafe_9999, 0);
    rw(0, 4'ha, 2, 0);
    chk(rd, 1);
    hit(0, 1, 4, 32'h0000_8000, 64'hbeef_1234_cafe_0000, 0);
    i_cpu.side(0, 8'h00);
    hit(0, 1, 4, 32'h0000_8000, 64'hcafe_0001_cafe_0002, 0);
    i_cpu.side(1, 8'h00);
    hit(0, 1, 4, 32'h0000_8000, 64'hcafe_0001_cafe_0002, 6);
    rw(1, 4'hb, 2, 0);
    rw(1, 4'h4, 2, 32'h0200_0023);
    rw(0, 4'h4, 2, 0);
    hit(0, 0, 3, 32'h0000_8000, 0, 0);
    hit(0, 0, 3, 32'h1234_5000, 0, 4'h5);
    hit(0, 0, 3, 32'h0000_8000, 0, 4'h7);
    rw(1, 4'h0, 2, 32'h0000_0013);
    for (i = 0; i < 3; i = i + 1) begin
      rw(1, 4'h1, 2, i + (i > 1));
      rw(0, 4'h1, 2, 0);
      hit(1, 0, 3, 32'h1234_5000, 0, {i == 2, i > 0, 2'b11});
    end
    rw(1, 4'h2, 2, 32'h1234_5001);
    hit(1, 0, 3, 32'h1234_5001, 0, 4'h3);
    $display("sequence and fetch test done");
    test_done;
  end
endmodule // testbench
